// *** design/awwd_pkg.sv ***
// package: constants and types of the front-end window watchdog
package awwd_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LOAD = 8'h04;
    localparam logic [7:0] REG_WINDOW = 8'h08;
    localparam logic [7:0] REG_SERVICE = 8'h0c;
    localparam logic [7:0] REG_COUNT = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam logic [7:0] REG_RSTCAUSE = 8'h1c;
    localparam logic [7:0] REG_KEEP = 8'h20;
    localparam logic [7:0] REG_KEEPCLS = 8'h24;
    // control fields
    localparam int CTRL_WD_EN = 0;
    localparam int CTRL_WAKE_EN = 1;
    localparam int CTRL_WAKE_SEL_LO = 4;
    localparam int CTRL_WAKE_SEL_W = 3;
    // status and mask bits
    localparam int ST_WAKE = 0;
    localparam int ST_EARLY = 1;
    localparam int ST_EXPIRE = 2;
    localparam int ST_W = 3;
    // service key
    localparam logic [31:0] SERVICE_KEY = 32'h0000_5a5a;
    // reset values
    localparam logic [15:0] LOAD_RESET = 16'hffff;
    localparam logic [15:0] WINDOW_RESET = 16'hffff;
    // low-power oscillator ticks of 32768 Hz per 125 ms
    localparam int LP_HZ = 32768;
    localparam int WAKE_BASE_MS = 125;
    localparam int WAKE_BASE_TICKS = LP_HZ * WAKE_BASE_MS / 1000;
    // cause of last watchdog reset
    typedef enum logic [1:0] {AWWD_CAUSE_NONE, AWWD_CAUSE_EXPIRE,
                              AWWD_CAUSE_EARLY} awwd_cause_t;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } awwd_req_t;
endpackage

// *** design/awwd_tick_div.sv ***
// divider that turns the system clock into low-power oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module awwd_tick_div #(
    parameter int DIV = 6104
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt;
    wire last = (cnt == W'(DIV - 1));

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt <= '0;
        else
            cnt <= last ? '0 : cnt + 1'b1;
    end

    assign tick = last;
endmodule // awwd_tick_div
`default_nettype wire

// *** design/awwd_top.sv ***
// window guard timer and wake-up timer of the battery front end
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module awwd_top #(
    parameter int LP_DIV = 6104,
    parameter int CNT_W = 16,
    parameter int RST_PULSE = 16
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    output logic WAKE,
    output logic CPU_RST_B,
    output logic AFE_RST_B
);
    // ==========================================================
    // bridge request
    awwd_pkg::awwd_req_t req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    wire sel_ctrl = (req.addr == awwd_pkg::REG_CTRL);
    wire sel_load = (req.addr == awwd_pkg::REG_LOAD);
    wire sel_win = (req.addr == awwd_pkg::REG_WINDOW);
    wire sel_svc = (req.addr == awwd_pkg::REG_SERVICE);
    wire sel_cnt = (req.addr == awwd_pkg::REG_COUNT);
    wire sel_st = (req.addr == awwd_pkg::REG_STATUS);
    wire sel_mask = (req.addr == awwd_pkg::REG_MASK);
    wire sel_cause = (req.addr == awwd_pkg::REG_RSTCAUSE);
    wire sel_keep = (req.addr == awwd_pkg::REG_KEEP);
    wire sel_cls = (req.addr == awwd_pkg::REG_KEEPCLS);

    wire wr_ctrl = req.wr && sel_ctrl;
    wire wr_load = req.wr && sel_load;
    wire wr_win = req.wr && sel_win;
    wire wr_mask = req.wr && sel_mask;
    wire wr_keep = req.wr && sel_keep;
    wire wr_cls = req.wr && sel_cls;
    wire wr_cause = req.wr && sel_cause;

    // ==========================================================
    // registers
    logic [7:0] ctrl;
    logic [CNT_W-1:0] load_val;
    logic [CNT_W-1:0] window_val;
    logic [CNT_W-1:0] countdown_value;
    logic [awwd_pkg::ST_W-1:0] status;
    logic [awwd_pkg::ST_W-1:0] mask;
    awwd_pkg::awwd_cause_t cause;
    logic [31:0] keep;
    logic [31:0] keep_cls;
    logic [31:0] rdata;
    // room for the longest period, 64 base periods
    localparam int WAKE_W = $clog2(awwd_pkg::WAKE_BASE_TICKS) + 7;
    logic [WAKE_W-1:0] wake_cnt;
    logic [7:0] rst_cnt;
    logic tick;

    // ==========================================================
    // low-power tick
    awwd_tick_div #(.DIV(LP_DIV)) u_div (
        .clk(CLK),
        .rst_b(RST_B),
        .tick(tick)
    );

    // ==========================================================
    // watchdog decode
    wire wd_en = ctrl[awwd_pkg::CTRL_WD_EN];
    wire in_reset = (rst_cnt != 8'h00);
    wire svc = req.wr && sel_svc && (req.wdata == awwd_pkg::SERVICE_KEY);
    wire early = wd_en && svc && (countdown_value > window_val);
    wire good_svc = wd_en && svc && !early;
    wire expire = wd_en && tick && (countdown_value == '0);
    wire trip = !in_reset && (early || expire);

    wire [CNT_W-1:0] next_count =
        !wd_en ? load_val :
        good_svc ? load_val :
        (tick && countdown_value != '0) ? countdown_value - 1'b1 :
        countdown_value;

    // ==========================================================
    // wake-up timer
    wire wake_en = ctrl[awwd_pkg::CTRL_WAKE_EN];
    wire [2:0] wake_sel = ctrl[awwd_pkg::CTRL_WAKE_SEL_LO +: 3];
    wire [2:0] wake_sh = (wake_sel > 3'h6) ? 3'h6 : wake_sel;
    wire [WAKE_W-1:0] wake_period =
        WAKE_W'(awwd_pkg::WAKE_BASE_TICKS) << wake_sh;
    wire [WAKE_W-1:0] wake_last = wake_period - 1'b1;
    wire wake_hit = wake_en && tick && (wake_cnt >= wake_last);

    // ==========================================================
    // status and interrupt
    wire rd_st = req.rd && sel_st;
    wire [awwd_pkg::ST_W-1:0] ev = {expire, early, wake_hit};
    wire [awwd_pkg::ST_W-1:0] next_status = (rd_st ? '0 : status) | ev;

    // ==========================================================
    // read mux
    wire [31:0] next_rdata =
        sel_ctrl ? {24'h0, ctrl} :
        sel_load ? 32'(load_val) :
        sel_win ? 32'(window_val) :
        sel_cnt ? 32'(countdown_value) :
        sel_st ? {29'h0, status} :
        sel_mask ? {29'h0, mask} :
        sel_cause ? {30'h0, cause} :
        sel_keep ? keep :
        sel_cls ? keep_cls :
        32'h0;

    // ==========================================================
    // next values of the configuration registers
    wire [7:0] next_ctrl =
        trip ? 8'h00 :
        wr_ctrl ? req.wdata[7:0] :
        ctrl;
    wire [CNT_W-1:0] next_load =
        trip ? CNT_W'(awwd_pkg::LOAD_RESET) :
        wr_load ? req.wdata[CNT_W-1:0] :
        load_val;
    wire [CNT_W-1:0] next_window =
        trip ? CNT_W'(awwd_pkg::WINDOW_RESET) :
        wr_win ? req.wdata[CNT_W-1:0] :
        window_val;
    wire [awwd_pkg::ST_W-1:0] next_mask =
        trip ? '0 :
        wr_mask ? req.wdata[awwd_pkg::ST_W-1:0] :
        mask;

    // ==========================================================
    // next values of the retained data
    wire [31:0] next_keep =
        trip ? (keep & keep_cls) :
        wr_keep ? req.wdata :
        keep;
    wire [31:0] next_keep_cls =
        (!trip && wr_cls) ? req.wdata : keep_cls;

    // ==========================================================
    // next values of the counters, cause and read data
    wire [CNT_W-1:0] next_countdown =
        trip ? CNT_W'(awwd_pkg::LOAD_RESET) : next_count;
    wire [WAKE_W-1:0] next_wake_cnt =
        (!wake_en || wake_hit) ? '0 :
        tick ? wake_cnt + 1'b1 :
        wake_cnt;
    wire [31:0] next_rd = req.rd ? next_rdata : 32'h0;
    awwd_pkg::awwd_cause_t next_cause;
    always_comb
    begin
        next_cause = cause;
        if (trip)
            next_cause = early ? awwd_pkg::AWWD_CAUSE_EARLY
                               : awwd_pkg::AWWD_CAUSE_EXPIRE;
        else if (wr_cause)
            next_cause = awwd_pkg::AWWD_CAUSE_NONE;
    end

    // ==========================================================
    // configuration registers, set back to their reset values by a watchdog reset
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            ctrl <= 8'h00;
        else
            ctrl <= next_ctrl;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            load_val <= CNT_W'(awwd_pkg::LOAD_RESET);
        else
            load_val <= next_load;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            window_val <= CNT_W'(awwd_pkg::WINDOW_RESET);
        else
            window_val <= next_window;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            mask <= '0;
        else
            mask <= next_mask;
    end

    // ==========================================================
    // retained data with per-bit reset class
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            keep <= 32'h0;
        else
            keep <= next_keep;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            keep_cls <= 32'h0;
        else
            keep_cls <= next_keep_cls;
    end

    // ==========================================================
    // countdown and wake counter
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            countdown_value <= CNT_W'(awwd_pkg::LOAD_RESET);
        else
            countdown_value <= next_countdown;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            wake_cnt <= '0;
        else
            wake_cnt <= next_wake_cnt;
    end

    // ==========================================================
    // status, cause and read data
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            status <= '0;
        else
            status <= next_status;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            cause <= awwd_pkg::AWWD_CAUSE_NONE;
        else
            cause <= next_cause;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            rdata <= 32'h0;
        else
            rdata <= next_rd;
    end

    // ==========================================================
    // reset pulse generator
    wire [7:0] next_rst_cnt =
        trip ? 8'(RST_PULSE) :
        in_reset ? rst_cnt - 8'h01 :
        rst_cnt;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            rst_cnt <= 8'h00;
        else
            rst_cnt <= next_rst_cnt;
    end

    // ==========================================================
    // wake pulse
    logic wake_q;
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            wake_q <= 1'b0;
        else
            wake_q <= wake_hit;
    end

    // ==========================================================
    // outputs
    assign RDATA = rdata;
    assign IRQ = |(status & mask);
    assign WAKE = wake_q;
    assign CPU_RST_B = !in_reset;
    assign AFE_RST_B = !in_reset;
endmodule // awwd_top
`default_nettype wire

// *** verif/awwd_top_asserts.sv ***
// port checker of the front-end window watchdog
`timescale 1ns/1ps
`default_nettype none
module awwd_top_asserts #(
    parameter int RST_PULSE = 16
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] ADDR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic WAKE,
    input wire logic CPU_RST_B,
    input wire logic AFE_RST_B
);
    // ==========
    // reset pulse length counter
    logic [7:0] low_cnt;
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            low_cnt <= 8'h00;
        else
            low_cnt <= CPU_RST_B ? 8'h00 : low_cnt + 8'h01;
    end
    // ==========
    // properties
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_rst_outs_same: assert property (CPU_RST_B == AFE_RST_B)
        else $error("reset outputs differ");
    a_pulse_len: assert property ($rose(CPU_RST_B) |->
        low_cnt == 8'(RST_PULSE)) else $error("reset pulse length");
    a_pulse_max: assert property (low_cnt <= 8'(RST_PULSE))
        else $error("reset pulse too long");
    a_rd_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data without read");
    a_rd_unmapped: assert property ($past(RD) &&
        $past(ADDR) > 8'h24 |-> RDATA == 32'h0) else $error("unmapped read");
    a_wake_pulse: assert property (WAKE |=> !WAKE [*8])
        else $error("wake pulse too long");
    a_cause_flag: assert property ($past(RD) && !$past(CPU_RST_B) &&
        $past(ADDR) == awwd_pkg::REG_RSTCAUSE |-> RDATA inside {32'h1, 32'h2})
        else $error("cause flag missing");
    a_count_reload: assert property ($past(RD) && !$past(CPU_RST_B) &&
        $past(ADDR) == awwd_pkg::REG_COUNT |-> RDATA == 32'h0000ffff)
        else $error("count not reloaded");
endmodule // awwd_top_asserts
bind awwd_top awwd_top_asserts #(.RST_PULSE(RST_PULSE)) u_chk (.CLK(CLK),
    .RST_B(RST_B), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .WAKE(WAKE),
    .CPU_RST_B(CPU_RST_B), .AFE_RST_B(AFE_RST_B));
`default_nettype wire

// *** verif/tb_awwd_top.sv ***
// testbench of the front-end window watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_awwd_top;
    localparam int LPD = 2;
    localparam int WK = awwd_pkg::WAKE_BASE_TICKS * LPD;
    logic CLK, RST_B, WR, RD, IRQ, WAKE, CPU_RST_B, AFE_RST_B;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA;
    int error_cnt = 0, cmp_count = 0, cyc = 0, trips = 0, t0;
    awwd_top #(.LP_DIV(LPD)) dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
        .WAKE(WAKE), .CPU_RST_B(CPU_RST_B), .AFE_RST_B(AFE_RST_B));
    // ==========
    // clock, timeout, trip monitor
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    always @(negedge CPU_RST_B) trips++;
    // ==========
    // tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, e, n);
    endtask
    task wait_rst(input logic v);
        for (int i = 0; i < 400 && CPU_RST_B !== v; i++) @(posedge CLK) #1;
        chk(AFE_RST_B, v, "afe reset");
    endtask
    task wait_wake;
        for (int i = 0; i < 20000 && WAKE !== 1'b1; i++) @(posedge CLK) #1;
        chk(WAKE, 1'b1, "wake seen");
    endtask
    task end_sim;
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========
    // main sequence
    initial
    begin
        RST_B = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0;
        repeat (4) @(posedge CLK);
        RST_B <= 1'b1;
        rd(awwd_pkg::REG_LOAD, 32'h0000ffff, "load");
        rd(awwd_pkg::REG_WINDOW, 32'h0000ffff, "window");
        rd(8'h30, 32'h0, "unmapped");
        wr(awwd_pkg::REG_KEEP, 32'hff);
        wr(awwd_pkg::REG_KEEPCLS, 32'h0f);
        wr(awwd_pkg::REG_LOAD, 32'h3);
        wr(awwd_pkg::REG_WINDOW, 32'h3);
        wr(awwd_pkg::REG_CTRL, 32'h1);
        wait_rst(1'b0);
        rd(awwd_pkg::REG_RSTCAUSE, 32'h1, "cause expire");
        rd(awwd_pkg::REG_COUNT, 32'h0000ffff, "count");
        wait_rst(1'b1);
        chk(trips, 1, "trips");
        rd(awwd_pkg::REG_KEEP, 32'h0f, "keep");
        rd(awwd_pkg::REG_LOAD, 32'h0000ffff, "load after trip");
        chk(IRQ, 1'b0, "irq masked");
        wr(awwd_pkg::REG_MASK, 32'h4);
        chk(IRQ, 1'b1, "irq raised");
        rd(awwd_pkg::REG_STATUS, 32'h4, "status");
        chk(IRQ, 1'b0, "irq cleared");
        wr(awwd_pkg::REG_RSTCAUSE, 32'h0);
        wr(awwd_pkg::REG_LOAD, 32'h64);
        wr(awwd_pkg::REG_WINDOW, 32'h0a);
        wr(awwd_pkg::REG_CTRL, 32'h1);
        wr(awwd_pkg::REG_SERVICE, 32'h1234);
        chk(CPU_RST_B, 1'b1, "bad key ignored");
        wr(awwd_pkg::REG_SERVICE, awwd_pkg::SERVICE_KEY);
        chk(CPU_RST_B, 1'b0, "early trip at once");
        wait_rst(1'b0);
        rd(awwd_pkg::REG_RSTCAUSE, 32'h2, "cause early");
        rd(awwd_pkg::REG_STATUS, 32'h2, "status early");
        wait_rst(1'b1);
        wr(awwd_pkg::REG_LOAD, 32'h14);
        wr(awwd_pkg::REG_WINDOW, 32'h14);
        wr(awwd_pkg::REG_CTRL, 32'h1);
        repeat (10)
        begin
            repeat (30) @(posedge CLK);
            wr(awwd_pkg::REG_SERVICE, awwd_pkg::SERVICE_KEY);
        end
        wr(awwd_pkg::REG_CTRL, 32'h2);
        chk(trips, 2, "serviced trips");
        wait_wake();
        t0 = cyc;
        @(posedge CLK) #1;
        wait_wake();
        chk(32'(cyc - t0), 32'(WK), "wake");
        t0 = cyc;
        rd(awwd_pkg::REG_STATUS, 32'h1, "status wake");
        wr(awwd_pkg::REG_CTRL, 32'h12);
        wait_wake();
        chk(32'(cyc - t0), 32'(2 * WK), "wake 250 ms");
        end_sim();
    end
endmodule // tb_awwd_top
`default_nettype wire
